// ==== src/led_pulse_train_generator.sv ====
// led pulse train generator: registers, position sequencer and led drive
`timescale 1ns/100ps
`include "led_pulse_cfg.svh"

module led_pulse_train_generator #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // register access from the serial core
  input  wire led_pulse_pkg::reg_req_t  reg_req,
  output logic [7:0]                    reg_rdata,
  // indicator
  output logic                          led_on,
  output logic [3:0]                    pattern_pos
);

  // ========================================================================
  // decode helpers

  // last position for a length select
  function automatic logic [3:0] last_pos_of(input logic [1:0] len);
    case (len)
      2'b00: last_pos_of = 4'hb;
      2'b01: last_pos_of = 4'h9;
      2'b10: last_pos_of = 4'h8;
      default: last_pos_of = 4'h7;
    endcase
  endfunction

  // prescaled ticks per position for a duration select
  function automatic logic [3:0] ticks_of(input logic [1:0] dur);
    case (dur)
      2'b00: ticks_of = 4'(`DUR_TICKS(`DUR_00_US));
      2'b01: ticks_of = 4'(`DUR_TICKS(`DUR_01_US));
      2'b10: ticks_of = 4'(`DUR_TICKS(`DUR_10_US));
      default: ticks_of = 4'(`DUR_TICKS(`DUR_11_US));
    endcase
  endfunction

  // ========================================================================
  // registers

  logic [7:0]                  pattern_low_byte_reg;
  led_pulse_pkg::ctrl_fields_t pattern_control_high_reg;
  logic [7:0]                  rdata_next;

  // software writes to the two registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pattern_low_byte_reg     <= `RST_PATTERN_LOW_BYTE;
      pattern_control_high_reg <= `RST_PATTERN_CONTROL_HIGH;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `OFS_PATTERN_LOW_BYTE) begin
        pattern_low_byte_reg <= reg_req.wdata; // [R01]
      end else if (reg_req.addr == `OFS_PATTERN_CONTROL_HIGH) begin
        pattern_control_high_reg <= reg_req.wdata; // [R03] [R04]
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    if (reg_req.addr == `OFS_PATTERN_LOW_BYTE) begin
      rdata_next = pattern_low_byte_reg;
    end else if (reg_req.addr == `OFS_PATTERN_CONTROL_HIGH) begin
      rdata_next = pattern_control_high_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  // read data held until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ========================================================================
  // timebase

  logic tick;

  led_tick_prescaler #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_prescaler (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // ========================================================================
  // position sequencer

  logic [11:0] pattern_w;
  logic [3:0]  last_pos;
  logic [3:0]  dur_ticks;
  logic [3:0]  tick_cnt_reg;
  logic [3:0]  pos_reg;
  logic        hold_done;
  logic        over_range;

  // twelve-bit pattern, control low nibble on top
  assign pattern_w  = {pattern_control_high_reg.pat_hi, pattern_low_byte_reg}; // [R01]
  assign last_pos   = last_pos_of(pattern_control_high_reg.len_sel); // [R04]
  assign dur_ticks  = ticks_of(pattern_control_high_reg.dur_sel); // [R03]
  assign hold_done  = tick && (tick_cnt_reg >= dur_ticks - 4'h1); // [R07]
  assign over_range = (pos_reg > last_pos);

  // ticks spent on the current position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 4'h0;
    end else if (over_range || hold_done) begin
      tick_cnt_reg <= 4'h0;
    end else if (tick) begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1; // [R03]
    end
  end

  // position advance and wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 4'h0;
    end else if (over_range) begin
      pos_reg <= 4'h0; // [R04]
    end else if (hold_done) begin
      if (pos_reg == last_pos) begin
        pos_reg <= 4'h0; // [R05]
      end else begin
        pos_reg <= pos_reg + 4'h1; // [R01]
      end
    end
  end

  // led follows the bit at the current position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      led_on <= 1'b0;
    end else begin
      led_on <= pattern_w[pos_reg]; // [R02]
    end
  end

  assign pattern_pos = pos_reg;

  // ========================================================================
  // checks

  AST_LED_FOLLOWS: assert property ( // [R02]
    @(posedge clock) disable iff (!rst_n)
    $stable(pos_reg) && $stable(pattern_w) |-> led_on == pattern_w[pos_reg]
  ) else $error("led does not follow pattern bit");

  AST_WRAP_TO_ZERO: assert property ( // [R05]
    @(posedge clock) disable iff (!rst_n)
    hold_done && !over_range && pos_reg == last_pos |=> pos_reg == 4'h0
  ) else $error("position did not wrap to zero");

  AST_STEP_ONE: assert property ( // [R01]
    @(posedge clock) disable iff (!rst_n)
    hold_done && pos_reg < last_pos |=> pos_reg == $past(pos_reg) + 4'h1
  ) else $error("position did not step by one");

  AST_LENGTH_BOUND: assert property ( // [R04]
    @(posedge clock) disable iff (!rst_n)
    pos_reg > last_pos |=> pos_reg == 4'h0
  ) else $error("position beyond selected length");

  AST_HOLD_COUNT: assert property ( // [R03]
    @(posedge clock) disable iff (!rst_n)
    tick && !over_range && tick_cnt_reg < dur_ticks - 4'h1
      |=> $stable(pos_reg) && tick_cnt_reg == $past(tick_cnt_reg) + 4'h1
  ) else $error("position left before duration elapsed");

  AST_ONLY_ON_TICK: assert property ( // [R07]
    @(posedge clock) disable iff (!rst_n)
    !tick && !over_range |=> $stable(pos_reg) && $stable(tick_cnt_reg)
  ) else $error("sequencer moved without a tick");

  AST_LOW_WRITE: assert property ( // [R01]
    @(posedge clock) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == `OFS_PATTERN_LOW_BYTE
      |=> pattern_w[7:0] == $past(reg_req.wdata)
  ) else $error("pattern low byte not written");

  AST_CTRL_WRITE: assert property ( // [R04]
    @(posedge clock) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == `OFS_PATTERN_CONTROL_HIGH
      |=> last_pos == last_pos_of($past(reg_req.wdata[`FLD_LEN_HI:`FLD_LEN_LO]))
  ) else $error("length select not written");

  AST_DUR_WRITE: assert property ( // [R03]
    @(posedge clock) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == `OFS_PATTERN_CONTROL_HIGH
      |=> dur_ticks == ticks_of($past(reg_req.wdata[`FLD_DUR_HI:`FLD_DUR_LO]))
  ) else $error("duration select not written");

  AST_HIGH_WRITE: assert property ( // [R01]
    @(posedge clock) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == `OFS_PATTERN_CONTROL_HIGH
      |=> pattern_w[11:8] == $past(reg_req.wdata[`FLD_PAT_HI:`FLD_PAT_LO])
  ) else $error("pattern high nibble not written");

  AST_HOLD_RESTART: assert property ( // [R03]
    @(posedge clock) disable iff (!rst_n)
    hold_done || over_range |=> tick_cnt_reg == 4'h0
  ) else $error("hold count not restarted");

  AST_READ_LOW: assert property ( // [R01]
    @(posedge clock) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == `OFS_PATTERN_LOW_BYTE
      |=> reg_rdata == $past(pattern_w[7:0])
  ) else $error("low byte read back wrong");

  AST_READ_HIGH: assert property ( // [R01]
    @(posedge clock) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == `OFS_PATTERN_CONTROL_HIGH
      |=> reg_rdata[3:0] == $past(pattern_w[11:8])
  ) else $error("high nibble read back wrong");

endmodule

// ==== src/led_pulse_cfg.svh ====
// constants for the led pulse train generator
//
// Overview of operation
// (R01) twelve-bit pattern, low byte first, position 0 first
// (R02) one bit lights led, zero bit darkens
// (R03) bits 7:6 choose per-position hold duration
// (R04) bits 5:4 choose length 12/10/9/8
// (R05) after last position restart at position 0
// (R06) host enables sync pin and clock-select value; no sync pin or clock select here, TICK_CYCLES fixes the tick
// (R07) durations are exact counts of prescaled ticks
`ifndef LED_PULSE_CFG_SVH
`define LED_PULSE_CFG_SVH

// ==========================================================================
// register map
`define OFS_PATTERN_LOW_BYTE     8'h7c
`define OFS_PATTERN_CONTROL_HIGH 8'h7d
`define RST_PATTERN_LOW_BYTE     8'h00
`define RST_PATTERN_CONTROL_HIGH 8'h00

// ==========================================================================
// field positions in the control register
`define FLD_DUR_HI 7
`define FLD_DUR_LO 6
`define FLD_LEN_HI 5
`define FLD_LEN_LO 4
`define FLD_PAT_HI 3
`define FLD_PAT_LO 0

// ==========================================================================
// timing: durations in microseconds, tick is a third of the shortest
`define CLK_PERIOD_NS 10
`define DUR_00_US     41670
`define DUR_01_US     55550
`define DUR_10_US     83330
`define DUR_11_US     125000
`define TICK_US       13889
`define TICK_CYCLES   ((`TICK_US * 1000) / `CLK_PERIOD_NS)
`define DUR_TICKS(d)  (((d) + (`TICK_US / 2)) / `TICK_US)

`endif

// ==== src/led_pulse_pkg.sv ====
// types shared by the led pulse train generator
package led_pulse_pkg;

  // fields of the control register
  typedef struct packed {
    logic [1:0] dur_sel;
    logic [1:0] len_sel;
    logic [3:0] pat_hi;
  } ctrl_fields_t;

  // one register access from the serial core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ==== src/led_tick_prescaler.sv ====
// core clock prescaler giving the pulse train timebase
`timescale 1ns/100ps
`include "led_pulse_cfg.svh"

module led_tick_prescaler #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // timebase
  output logic      tick
);

  localparam int W = $clog2(TICK_CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] cnt_reg;

  // free running divider, one-cycle pulse at wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  assign tick = (cnt_reg >= LAST); // [R07]

endmodule

// ==== tb/led_indicator_model.sv ====
// indicator led on the far side of the drive output
`timescale 1ns/100ps

module led_indicator_model (
  // clock
  input  wire logic clock,
  // drive from the generator
  input  wire logic led_on,
  // observation
  output int        lit_cycles
);
  // ==========================================================================
  // lamp
  // the lamp glows only while driven; counting lit cycles lets a dark
  // setting be proven without trusting the generator's own view
  initial lit_cycles = 0;
  always @(posedge clock) begin
    if (led_on === 1'b1) begin
      lit_cycles <= lit_cycles + 1;
    end
  end
endmodule

// ==== tb/led_pulse_train_generator_test.sv ====
// self-checking bench for the led pulse train generator
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module led_pulse_train_generator_test;
  // ==========================================================================
  // signals
  logic                    clock;
  logic                    rst_n;
  led_pulse_pkg::reg_req_t reg_req;
  logic [7:0]              reg_rdata;
  logic [7:0]              d;
  logic                    led_on;
  logic [3:0]              pattern_pos;
  logic [11:0]             pat;
  int                      lit_cycles;
  int                      mismatches;
  int                      checks;
  int                      cyc;
  int                      k;
  int                      lit0;
  // rows: low byte, control, hold cycles at four clocks a tick, last position
  logic [7:0] rows [4][4] = '{'{8'h45, 8'h01, 8'h0c, 8'h0b},
                              '{8'ha5, 8'h5c, 8'h10, 8'h09},
                              '{8'h3c, 8'ha3, 8'h18, 8'h08},
                              '{8'h96, 8'hf9, 8'h24, 8'h07}};

  // ==========================================================================
  // design and lamp
  led_pulse_train_generator #(.TICK_CYCLES(4)) DUT (
    .clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .led_on(led_on), .pattern_pos(pattern_pos));
  led_indicator_model lamp (.clock(clock), .led_on(led_on), .lit_cycles(lit_cycles));

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = v;
    @(negedge clock);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clock);
    reg_req.rd = 1'b0;
    v = reg_rdata;
  endtask

  // program one row, then time positions 1 to the last and check the wrap back to position 0
  // no alignment with other generators wanted, so sync stays with the host
  task automatic run(input int i);
    int p;
    wr(8'h7c, rows[i][0]);
    wr(8'h7d, rows[i][1]);
    rd(8'h7d, d);
    `CHK("ctl rb", rows[i][1], d)
    pat = {rows[i][1][3:0], rows[i][0]};
    k = 0;
    while (pattern_pos !== 4'h0 && k < 999) begin
      @(negedge clock);
      k++;
    end
    while (pattern_pos !== 4'h1 && k < 1999) begin
      @(negedge clock);
      k++;
    end
    for (p = 1; p <= rows[i][3]; p++) begin
      k = 0;
      while (pattern_pos === p[3:0] && k < 99) begin
        @(negedge clock);
        k++;
        if (k == rows[i][2] / 2) `CHK("led", pat[p], led_on)
      end
      `CHK("hold", rows[i][2], k[7:0])
      `CHK("next", (p == rows[i][3]) ? 4'h0 : 4'(p + 1), pattern_pos)
    end
    repeat (2) @(negedge clock);
    `CHK("led wrap", pat[0], led_on)
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h7c, d);
    `CHK("low rst", 8'h00, d)
    rd(8'h7d, d);
    `CHK("ctl rst", 8'h00, d)
    for (int i = 0; i < 4; i++) run(i);
    // unmapped write ignored, unmapped read zero, last row kept
    wr(8'h7e, 8'h5a);
    rd(8'h7e, d);
    `CHK("unmapped", 8'h00, d)
    rd(8'h7c, d);
    `CHK("low rb", rows[3][0], d)
    // shrink the length below the current position
    wr(8'h7c, 8'hff);
    wr(8'h7d, 8'h0f);
    k = 0;
    while (pattern_pos !== 4'ha && k < 999) begin
      @(negedge clock);
      k++;
    end
    `CHK("lit", 1'b1, led_on)
    wr(8'h7d, 8'h3f);
    @(negedge clock);
    `CHK("shrink", 4'h0, pattern_pos)
    while (pattern_pos !== 4'h3 && k < 1999) begin
      @(negedge clock);
      k++;
    end
    `CHK("lit 2", 1'b1, led_on)
    // reset in mid-run clears position, drive and registers
    rst_n = 1'b0;
    @(negedge clock);
    `CHK("pos rst", 4'h0, pattern_pos)
    `CHK("led rst", 1'b0, led_on)
    rst_n = 1'b1;
    lit0 = lit_cycles;
    repeat (50) @(negedge clock);
    `CHK("dark", lit0, lit_cycles)
    rd(8'h7d, d);
    `CHK("ctl rst2", 8'h00, d)
    rd(8'h7c, d);
    `CHK("low rst2", 8'h00, d)
    wrap_up();
  end
endmodule
